// ### common/fwp_params.svh
// Constants of the flash write-protect and status block
`ifndef FWP_PARAMS_SVH
`define FWP_PARAMS_SVH

// Instruction codes
`define FWP_OP_STATUS_WRITE_COMMAND 8'h01
`define FWP_OP_PROG 8'h02
`define FWP_OP_WRITE_DISABLE_COMMAND 8'h04
`define FWP_OP_RDSR 8'h05
`define FWP_OP_WRITE_ENABLE_COMMAND 8'h06
`define FWP_OP_SECT 8'h20
`define FWP_OP_BLK32 8'h52
`define FWP_OP_BLK64 8'hd8
`define FWP_OP_CHIP_A 8'h60
`define FWP_OP_CHIP_B 8'hc7
`define FWP_OP_AAI 8'had
`define FWP_OP_SID_RD 8'h88
`define FWP_OP_SID_PROG 8'ha5
`define FWP_OP_SID_LOCK 8'h85

// Status register bit positions and reset values
`define FWP_ST_BUSY 0
`define FWP_ST_WEL 1
`define FWP_ST_BP_LO 2
`define FWP_ST_BP_HI 4
`define FWP_ST_SEC 5
`define FWP_ST_AAI 6
`define FWP_ST_BPL 7
`define FWP_BP_RESET 3'h7
`define FWP_BPL_RESET 1'b0

// Protection level codes and region bases
`define FWP_LVL_NONE 3'h0
`define FWP_LVL_16 3'h1
`define FWP_LVL_8 3'h2
`define FWP_LVL_4 3'h3
`define FWP_LVL_2 3'h4
`define FWP_BASE_16 20'hf0000
`define FWP_BASE_8 20'he0000
`define FWP_BASE_4 20'hc0000
`define FWP_BASE_2 20'h80000
`define FWP_ADDR_TOP 20'hfffff
`define FWP_MASK_SECT 20'h00fff
`define FWP_MASK_BLK32 20'h07fff
`define FWP_MASK_BLK64 20'h0ffff

// Frame lengths in bytes, opcode included
`define FWP_NB_CMD 3'h1
`define FWP_NB_STATUS_WRITE_COMMAND 3'h2
`define FWP_NB_SID_PROG 3'h3
`define FWP_NB_AAI_NEXT 3'h3
`define FWP_NB_ERASE 3'h4
`define FWP_NB_PROG 3'h5
`define FWP_NB_AAI_FIRST 3'h6
`define FWP_NB_SID_DATA 3'h2

// Security identifier layout
`define FWP_SID_FACTORY_BYTES 5'h08
`define FWP_SID_USER_BYTES 24
`define FWP_SID_BLANK 8'hff

// Timing
`define FWP_CLK_NS 10
`define FWP_PROG_TIME_NS 7000
`define FWP_ERASE_TIME_US 18000
`define FWP_CHIP_TIME_US 35000
`define FWP_PROG_CYC ((`FWP_PROG_TIME_NS + `FWP_CLK_NS - 1) / `FWP_CLK_NS)
`define FWP_ERASE_CYC (`FWP_ERASE_TIME_US * 1000 / `FWP_CLK_NS)
`define FWP_CHIP_CYC (`FWP_CHIP_TIME_US * 1000 / `FWP_CLK_NS)
`define FWP_CNT_W 24

`endif

// ### common/fwp_pkg.sv
// Shared types of the flash write-protect block
`default_nettype none
package fwp_pkg;
  typedef enum logic [3:0] {
    FWP_CMD_NONE, FWP_CMD_WRITE_ENABLE_COMMAND, FWP_CMD_WRITE_DISABLE_COMMAND, FWP_CMD_RDSR, FWP_CMD_STATUS_WRITE_COMMAND,
    FWP_CMD_PROG, FWP_CMD_SECT, FWP_CMD_BLK32, FWP_CMD_BLK64, FWP_CMD_CHIP,
    FWP_CMD_AAI, FWP_CMD_SID_RD, FWP_CMD_SID_PROG, FWP_CMD_SID_LOCK
  } fwp_cmd_e;
  typedef enum logic [1:0] {
    FWP_ER_SECTOR, FWP_ER_BLK32, FWP_ER_BLK64, FWP_ER_CHIP
  } fwp_erase_e;
  typedef enum logic {FWP_READY, FWP_WORKING} fwp_state_e;
endpackage
`default_nettype wire

// ### rtl/fwp_prot_decode.sv
// Decodes whether an address falls in the protected top region
`timescale 1ns/1ps
`default_nettype none
`include "fwp_params.svh"

module fwp_prot_decode
(
  input wire logic [2:0] i_level, // Level code {high, mid, low}
  input wire logic [19:0] i_last, // Highest address of the range
  output logic o_hit // Range touches protected space
);
  // Regions all end at the top, so the highest address decides
  always_comb
  begin
    case (i_level)
      `FWP_LVL_NONE: o_hit = 1'b0;
      `FWP_LVL_16: o_hit = (i_last >= `FWP_BASE_16);
      `FWP_LVL_8: o_hit = (i_last >= `FWP_BASE_8);
      `FWP_LVL_4: o_hit = (i_last >= `FWP_BASE_4);
      `FWP_LVL_2: o_hit = (i_last >= `FWP_BASE_2);
      default: o_hit = 1'b1;
    endcase
  end
endmodule
`default_nettype wire

// ### rtl/fwp_secid_store.sv
// Security identifier storage: fixed factory part, program-only user part
`timescale 1ns/1ps
`default_nettype none
`include "fwp_params.svh"

module fwp_secid_store
#(
  parameter logic [63:0] P_FACTORY_ID = 64'h5a5a_1234_c3c3_9876 // Arbitrary
)
(
  input wire logic i_clock, // System clock
  input wire logic i_rst_n, // Asynchronous reset, active low
  input wire logic i_wr, // Program one byte
  input wire logic [4:0] i_wr_idx, // Byte index to program
  input wire logic [7:0] i_wr_data, // Byte value to program
  input wire logic [4:0] i_rd_idx, // Byte index to read
  output logic [7:0] o_rd_data // Byte read
);
  logic [7:0] user_q [`FWP_SID_USER_BYTES];
  logic [4:0] user_idx;

  assign user_idx = i_wr_idx - `FWP_SID_FACTORY_BYTES;

  // No erase path exists; programming can only clear bits
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      for (int i = 0; i < `FWP_SID_USER_BYTES; i++)
        user_q[i] <= `FWP_SID_BLANK;
    end
    else if (i_wr && i_wr_idx >= `FWP_SID_FACTORY_BYTES)
      user_q[user_idx] <= user_q[user_idx] & i_wr_data;
  end

  always_comb
  begin
    if (i_rd_idx < `FWP_SID_FACTORY_BYTES)
      o_rd_data = P_FACTORY_ID[8 * (7 - i_rd_idx[2:0]) +: 8];
    else
      o_rd_data = user_q[5'(i_rd_idx - `FWP_SID_FACTORY_BYTES)];
  end
endmodule
`default_nettype wire

// ### rtl/fwp_write_protect.sv
// Status register, write protection and security lock of a serial flash
// What this block does
// - Status write refused when pin low, lock set
// - Identifier: 64 fixed bits, 192 user bits
// - Factory part never programmed; nothing erasable
// - After lockout, identifier writes are rejected
// - While busy only status reads are honoured
// - Bit 0 busy, read-only, clear at reset
// - Bit 1 shows latch; clear blocks writes
// - Latch clears after writes and disable
// - Bits 2-4 levels, writable, reset ones
// - Bit 5 lock flag, sticky, survives reset
// - Bit 6 shows auto-increment mode, default zero
// - Bit 7 freezes levels when pin low
// - Block writes inside the protected region
// - Chip erase only with all levels zero
// - Code 000 none, 001 to 011 select small regions
// - Code 100 half, 101-111 whole array
`timescale 1ns/1ps
`default_nettype none
`include "fwp_params.svh"

module fwp_write_protect
#(
  parameter int P_PROG_CYC = `FWP_PROG_CYC, // Program busy cycles
  parameter int P_ERASE_CYC = `FWP_ERASE_CYC, // Sector/block erase cycles
  parameter int P_CHIP_CYC = `FWP_CHIP_CYC, // Chip erase cycles
  parameter logic [63:0] P_FACTORY_ID = 64'h5a5a_1234_c3c3_9876 // Arbitrary
)
(
  input wire logic i_clock, // 100 MHz system clock
  input wire logic i_rst_n, // Asynchronous power-up reset, active low
  input wire logic i_sck, // Serial clock pin
  input wire logic i_ce_n, // Chip enable pin, active low
  input wire logic i_si, // Serial data input pin
  input wire logic i_wp_n, // Write protect pin, active low
  input wire logic i_secid_lock_nv, // Stored lock state from nonvolatile
  output logic o_so, // Serial data output
  output logic o_so_oe, // High while o_so is driven
  output logic o_prog_valid, // One-cycle program request to array
  output logic o_prog_word, // Request holds two bytes
  output logic [19:0] o_prog_addr, // First byte address
  output logic [15:0] o_prog_data, // First byte in upper half
  output logic o_erase_valid, // One-cycle erase request to array
  output var fwp_pkg::fwp_erase_e o_erase_kind, // Erase size
  output logic [19:0] o_erase_addr, // First address of erased range
  output logic o_secid_lock_set, // One cycle: persist the lock
  output logic [7:0] o_status // Copy of the status register
);
  logic [2:0] sck_sync_q;
  logic [2:0] ce_sync_q;
  logic [1:0] si_sync_q;
  logic [1:0] wp_sync_q;
  logic sck_rise, sck_fall, ce_rise, ce_fall, active, wp_s;
  logic [2:0] bit_cnt_q, byte_cnt_q;
  logic [7:0] shift_q, new_byte, opcode_q, out_sh_q, sid_rd_data;
  logic [23:0] addr_q;
  logic [15:0] data_q;
  logic [4:0] rd_idx_q;
  logic byte_done, exec, busy, load_status, load_sid;
  fwp_pkg::fwp_cmd_e cmd;
  fwp_pkg::fwp_state_e state_q;
  logic [`FWP_CNT_W-1:0] cnt_q;
  logic wel_q, aai_q, bpl_q, sec_lock_q, nv_loaded_q, end_pend_q;
  logic [2:0] bp_q;
  logic [19:0] aai_ptr_q, chk_last, erase_mask;
  logic chk_hit, ptr_hit;
  logic acc_status_write_command, acc_prog, acc_erase, acc_chip, aai_first, aai_next;
  logic acc_sid_prog, acc_sid_lock, do_write_enable_command, do_write_disable_command, aai_stop, busy_end;
  logic [7:0] status_w;

  function automatic fwp_pkg::fwp_cmd_e cmd_of(input logic [7:0] op);
    case (op)
      `FWP_OP_WRITE_ENABLE_COMMAND: cmd_of = fwp_pkg::FWP_CMD_WRITE_ENABLE_COMMAND;
      `FWP_OP_WRITE_DISABLE_COMMAND: cmd_of = fwp_pkg::FWP_CMD_WRITE_DISABLE_COMMAND;
      `FWP_OP_RDSR: cmd_of = fwp_pkg::FWP_CMD_RDSR;
      `FWP_OP_STATUS_WRITE_COMMAND: cmd_of = fwp_pkg::FWP_CMD_STATUS_WRITE_COMMAND;
      `FWP_OP_PROG: cmd_of = fwp_pkg::FWP_CMD_PROG;
      `FWP_OP_SECT: cmd_of = fwp_pkg::FWP_CMD_SECT;
      `FWP_OP_BLK32: cmd_of = fwp_pkg::FWP_CMD_BLK32;
      `FWP_OP_BLK64: cmd_of = fwp_pkg::FWP_CMD_BLK64;
      `FWP_OP_CHIP_A: cmd_of = fwp_pkg::FWP_CMD_CHIP;
      `FWP_OP_CHIP_B: cmd_of = fwp_pkg::FWP_CMD_CHIP;
      `FWP_OP_AAI: cmd_of = fwp_pkg::FWP_CMD_AAI;
      `FWP_OP_SID_RD: cmd_of = fwp_pkg::FWP_CMD_SID_RD;
      `FWP_OP_SID_PROG: cmd_of = fwp_pkg::FWP_CMD_SID_PROG;
      `FWP_OP_SID_LOCK: cmd_of = fwp_pkg::FWP_CMD_SID_LOCK;
      default: cmd_of = fwp_pkg::FWP_CMD_NONE;
    endcase
  endfunction

  // Pin synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sck_sync_q <= 3'h0;
      ce_sync_q <= 3'h7;
      si_sync_q <= 2'h0;
      wp_sync_q <= 2'h0;
    end
    else
    begin
      sck_sync_q <= {sck_sync_q[1:0], i_sck};
      ce_sync_q <= {ce_sync_q[1:0], i_ce_n};
      si_sync_q <= {si_sync_q[0], i_si};
      wp_sync_q <= {wp_sync_q[0], i_wp_n};
    end
  end

  assign sck_rise = sck_sync_q[1] & ~sck_sync_q[2];
  assign sck_fall = ~sck_sync_q[1] & sck_sync_q[2];
  assign ce_rise = ce_sync_q[1] & ~ce_sync_q[2];
  assign ce_fall = ~ce_sync_q[1] & ce_sync_q[2];
  assign active = ~ce_sync_q[1];
  assign wp_s = wp_sync_q[1];
  assign new_byte = {shift_q[6:0], si_sync_q[1]};
  assign byte_done = active & sck_rise & (bit_cnt_q == 3'h7);
  assign cmd = cmd_of(opcode_q);
  assign busy = (state_q == fwp_pkg::FWP_WORKING);

  // Frame capture: opcode, three address bytes, two data bytes
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      bit_cnt_q <= 3'h0;
      byte_cnt_q <= 3'h0;
      shift_q <= 8'h00;
      opcode_q <= 8'h00;
      addr_q <= 24'h000000;
      data_q <= 16'h0000;
    end
    else if (ce_fall)
    begin
      bit_cnt_q <= 3'h0;
      byte_cnt_q <= 3'h0;
      opcode_q <= 8'h00;
    end
    else if (active && sck_rise)
    begin
      shift_q <= new_byte;
      bit_cnt_q <= bit_cnt_q + 3'h1;
      if (byte_done)
      begin
        if (byte_cnt_q != 3'h7)
          byte_cnt_q <= byte_cnt_q + 3'h1;
        case (byte_cnt_q)
          3'h0: opcode_q <= new_byte;
          3'h1: addr_q[23:16] <= new_byte;
          3'h2: addr_q[15:8] <= new_byte;
          3'h3: addr_q[7:0] <= new_byte;
          3'h4: data_q[15:8] <= new_byte;
          3'h5: data_q[7:0] <= new_byte;
          default: data_q <= data_q;
        endcase
      end
    end
  end

  // Status reads stay live so polling sees busy fall
  assign load_status = (byte_cnt_q == 3'h0) ?
    (cmd_of(new_byte) == fwp_pkg::FWP_CMD_RDSR) :
    (cmd == fwp_pkg::FWP_CMD_RDSR);
  assign load_sid = (cmd == fwp_pkg::FWP_CMD_SID_RD) && !busy &&
    (byte_cnt_q >= `FWP_NB_SID_DATA);

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      out_sh_q <= 8'h00;
      rd_idx_q <= 5'h00;
      o_so <= 1'b0;
      o_so_oe <= 1'b0;
    end
    else if (!active)
      o_so_oe <= 1'b0;
    else if (byte_done)
    begin
      if (load_status)
      begin
        out_sh_q <= status_w;
        o_so_oe <= 1'b1;
      end
      else if (load_sid)
      begin
        out_sh_q <= sid_rd_data;
        rd_idx_q <= rd_idx_q + 5'h01;
        o_so_oe <= 1'b1;
      end
      if (byte_cnt_q == 3'h1)
        rd_idx_q <= new_byte[4:0];
    end
    else if (sck_fall)
    begin
      o_so <= out_sh_q[7];
      out_sh_q <= {out_sh_q[6:0], 1'b0};
    end
  end

  // Protection checks: the command's range and the next auto word
  always_comb
  begin
    case (cmd)
      fwp_pkg::FWP_CMD_SECT: erase_mask = `FWP_MASK_SECT;
      fwp_pkg::FWP_CMD_BLK32: erase_mask = `FWP_MASK_BLK32;
      fwp_pkg::FWP_CMD_BLK64: erase_mask = `FWP_MASK_BLK64;
      fwp_pkg::FWP_CMD_AAI: erase_mask = 20'h00001;
      default: erase_mask = 20'h00000;
    endcase
    chk_last = addr_q[19:0] | erase_mask;
  end

  fwp_prot_decode u_prot_cmd
  (
    .i_level(bp_q),
    .i_last(chk_last),
    .o_hit(chk_hit)
  );

  fwp_prot_decode u_prot_ptr
  (
    .i_level(bp_q),
    .i_last(aai_ptr_q | 20'h00001),
    .o_hit(ptr_hit)
  );

  fwp_secid_store #(.P_FACTORY_ID(P_FACTORY_ID)) u_secid
  (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_wr(acc_sid_prog),
    .i_wr_idx(addr_q[20:16]),
    .i_wr_data(addr_q[15:8]),
    .i_rd_idx(rd_idx_q),
    .o_rd_data(sid_rd_data)
  );

  // Commands act at deselect, only on whole bytes and only when idle
  assign exec = ce_rise & (bit_cnt_q == 3'h0) & ~busy;
  assign do_write_enable_command = exec & (cmd == fwp_pkg::FWP_CMD_WRITE_ENABLE_COMMAND) &
    (byte_cnt_q == `FWP_NB_CMD) & ~aai_q;
  assign do_write_disable_command = exec & (cmd == fwp_pkg::FWP_CMD_WRITE_DISABLE_COMMAND) &
    (byte_cnt_q == `FWP_NB_CMD);
  assign acc_status_write_command = exec & (cmd == fwp_pkg::FWP_CMD_STATUS_WRITE_COMMAND) & wel_q & ~aai_q &
    (byte_cnt_q == `FWP_NB_STATUS_WRITE_COMMAND) & (wp_s | ~bpl_q);
  assign acc_prog = exec & (cmd == fwp_pkg::FWP_CMD_PROG) & wel_q & ~aai_q &
    (byte_cnt_q == `FWP_NB_PROG) & ~chk_hit;
  assign acc_erase = exec & wel_q & ~aai_q & ~chk_hit &
    (byte_cnt_q == `FWP_NB_ERASE) & (cmd == fwp_pkg::FWP_CMD_SECT ||
    cmd == fwp_pkg::FWP_CMD_BLK32 || cmd == fwp_pkg::FWP_CMD_BLK64);
  assign acc_chip = exec & (cmd == fwp_pkg::FWP_CMD_CHIP) & wel_q & ~aai_q &
    (byte_cnt_q == `FWP_NB_CMD) & (bp_q == `FWP_LVL_NONE);
  assign aai_first = exec & (cmd == fwp_pkg::FWP_CMD_AAI) & wel_q & ~aai_q &
    (byte_cnt_q == `FWP_NB_AAI_FIRST) & ~chk_hit;
  assign aai_next = exec & (cmd == fwp_pkg::FWP_CMD_AAI) & aai_q &
    (byte_cnt_q == `FWP_NB_AAI_NEXT) & ~ptr_hit;
  assign acc_sid_prog = exec & (cmd == fwp_pkg::FWP_CMD_SID_PROG) & wel_q &
    ~aai_q & ~sec_lock_q & (byte_cnt_q == `FWP_NB_SID_PROG);
  assign acc_sid_lock = exec & (cmd == fwp_pkg::FWP_CMD_SID_LOCK) & wel_q &
    ~aai_q & (byte_cnt_q == `FWP_NB_CMD);
  assign busy_end = busy & (cnt_q == `FWP_CNT_W'(1));
  assign aai_stop = busy_end & aai_q & (end_pend_q | ptr_hit);

  // Busy timer; a refused command never starts it
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_q <= fwp_pkg::FWP_READY;
      cnt_q <= '0;
    end
    else
    begin
      case (state_q)
        fwp_pkg::FWP_READY:
        begin
          if (acc_prog || aai_first || aai_next || acc_sid_prog)
          begin
            state_q <= fwp_pkg::FWP_WORKING;
            cnt_q <= `FWP_CNT_W'(P_PROG_CYC);
          end
          else if (acc_erase || acc_chip)
          begin
            state_q <= fwp_pkg::FWP_WORKING;
            cnt_q <= acc_chip ? `FWP_CNT_W'(P_CHIP_CYC) :
              `FWP_CNT_W'(P_ERASE_CYC);
          end
        end
        fwp_pkg::FWP_WORKING:
        begin
          cnt_q <= cnt_q - `FWP_CNT_W'(1);
          if (busy_end)
            state_q <= fwp_pkg::FWP_READY;
        end
        default: state_q <= fwp_pkg::FWP_READY;
      endcase
    end
  end

  // Write enable latch
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      wel_q <= 1'b0;
    else if (do_write_enable_command)
      wel_q <= 1'b1;
    else if (do_write_disable_command || acc_status_write_command || acc_prog || acc_erase || acc_chip ||
      acc_sid_prog || acc_sid_lock || aai_stop)
      wel_q <= 1'b0;
  end

  // Auto-increment mode and word pointer
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      aai_q <= 1'b0;
      aai_ptr_q <= 20'h00000;
      end_pend_q <= 1'b0;
    end
    else if (do_write_disable_command || aai_stop)
      aai_q <= 1'b0;
    else if (aai_first || aai_next)
    begin
      aai_q <= 1'b1;
      aai_ptr_q <= aai_first ? ((addr_q[19:0] & ~20'h00001) + 20'h00002) :
        (aai_ptr_q + 20'h00002);
      end_pend_q <= aai_first ? ((addr_q[19:0] | 20'h00001) == `FWP_ADDR_TOP)
        : ((aai_ptr_q | 20'h00001) == `FWP_ADDR_TOP);
    end
  end

  // Level and lock bits; a refused write leaves them untouched
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      bp_q <= `FWP_BP_RESET;
      bpl_q <= `FWP_BPL_RESET;
    end
    else if (acc_status_write_command)
    begin
      bp_q <= addr_q[16 + `FWP_ST_BP_HI:16 + `FWP_ST_BP_LO];
      bpl_q <= addr_q[16 + `FWP_ST_BPL];
    end
  end

  // Lock flag takes the stored state after release, then only sets
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sec_lock_q <= 1'b0;
      nv_loaded_q <= 1'b0;
      o_secid_lock_set <= 1'b0;
    end
    else
    begin
      nv_loaded_q <= 1'b1;
      o_secid_lock_set <= acc_sid_lock;
      if (!nv_loaded_q)
        sec_lock_q <= i_secid_lock_nv;
      else if (acc_sid_lock)
        sec_lock_q <= 1'b1;
    end
  end

  always_comb
  begin
    status_w = 8'h00;
    status_w[`FWP_ST_BUSY] = busy;
    status_w[`FWP_ST_WEL] = wel_q;
    status_w[`FWP_ST_BP_HI:`FWP_ST_BP_LO] = bp_q;
    status_w[`FWP_ST_SEC] = sec_lock_q;
    status_w[`FWP_ST_AAI] = aai_q;
    status_w[`FWP_ST_BPL] = bpl_q;
  end

  // Array requests
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_prog_valid <= 1'b0;
      o_prog_word <= 1'b0;
      o_prog_addr <= 20'h00000;
      o_prog_data <= 16'h0000;
      o_erase_valid <= 1'b0;
      o_erase_kind <= fwp_pkg::FWP_ER_SECTOR;
      o_erase_addr <= 20'h00000;
      o_status <= 8'h00;
    end
    else
    begin
      o_status <= status_w;
      o_prog_valid <= acc_prog | aai_first | aai_next;
      o_erase_valid <= acc_erase | acc_chip;
      if (acc_prog)
      begin
        o_prog_word <= 1'b0;
        o_prog_addr <= addr_q[19:0];
        o_prog_data <= {data_q[15:8], 8'h00};
      end
      else if (aai_first || aai_next)
      begin
        o_prog_word <= 1'b1;
        o_prog_addr <= aai_first ? (addr_q[19:0] & ~20'h00001) : aai_ptr_q;
        o_prog_data <= aai_first ? data_q : addr_q[23:8];
      end
      if (acc_chip)
      begin
        o_erase_kind <= fwp_pkg::FWP_ER_CHIP;
        o_erase_addr <= 20'h00000;
      end
      else if (acc_erase)
      begin
        o_erase_addr <= addr_q[19:0] & ~erase_mask;
        if (cmd == fwp_pkg::FWP_CMD_SECT)
          o_erase_kind <= fwp_pkg::FWP_ER_SECTOR;
        else if (cmd == fwp_pkg::FWP_CMD_BLK32)
          o_erase_kind <= fwp_pkg::FWP_ER_BLK32;
        else
          o_erase_kind <= fwp_pkg::FWP_ER_BLK64;
      end
    end
  end

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  status_write_command_lock_a: assert property (
    ce_rise && cmd == fwp_pkg::FWP_CMD_STATUS_WRITE_COMMAND && !wp_s && bpl_q
    |=> $stable(bp_q) && bpl_q)
    else $error("status write changed locked bits");
  busy_gate_a: assert property (
    busy && !aai_stop && ce_rise
    |=> !o_prog_valid && !o_erase_valid && $stable(wel_q))
    else $error("command acted while busy");
  wel_gate_a: assert property (
    ce_rise && !wel_q && !busy |=> !o_prog_valid && !o_erase_valid && !busy)
    else $error("write ran without enable latch");
  wel_clear_a: assert property (
    o_prog_valid || o_erase_valid |-> !wel_q || aai_q)
    else $error("latch still set after accepted write");
  chip_erase_a: assert property (
    o_erase_valid && o_erase_kind == fwp_pkg::FWP_ER_CHIP
    |-> $past(bp_q) == `FWP_LVL_NONE)
    else $error("chip erase with protection set");
  prot_block_a: assert property (
    exec && cmd == fwp_pkg::FWP_CMD_PROG && chk_hit
    |=> !o_prog_valid ##1 !busy)
    else $error("protected program was started");
  secid_sticky_a: assert property (
    nv_loaded_q && sec_lock_q |=> sec_lock_q [*8])
    else $error("lock flag returned to zero");
  level_freeze_a: assert property (
    !wp_s && bpl_q && !$changed(wp_s) |=> $stable(bp_q) && $stable(bpl_q))
    else $error("levels changed while frozen");
  busy_status_a: assert property (
    o_prog_valid |-> busy && status_w[`FWP_ST_BUSY] ##1 o_status[0])
    else $error("busy bit not shown during program");
  aai_status_a: assert property (
    aai_first |=> aai_q && o_prog_word ##1 o_status[`FWP_ST_AAI])
    else $error("mode bit not set by auto-increment");
endmodule
`default_nettype wire

// ### test/fwp_host_model.sv
// Host serial controller model that drives command frames into the block
`timescale 1ns/1ps
`default_nettype none
module fwp_host_model
(
  input wire logic i_so, // Serial data from the block
  input wire logic i_so_oe, // High while the block drives i_so
  output logic o_sck, // Serial clock, stands low outside frames
  output logic o_ce_n, // Chip enable, active low
  output logic o_si, // Serial data to the block
  output logic o_rx_valid, // Rises when a checked byte is captured
  output logic [7:0] o_rx // Last byte captured
);
  initial
  begin
    o_sck = 1'b0;
    o_ce_n = 1'b1;
    o_si = 1'b0;
    o_rx_valid = 1'b0;
    o_rx = 8'h00;
  end
  // Mode 0 at 125 ns: data set while low, both sides sample on the rise
  task automatic xfer(input logic [47:0] tx, input int nb, input bit chk,
    output logic [7:0] rx);
    rx = 8'h00;
    o_ce_n <= 1'b0;
    for (int i = 8 * nb - 1; i >= 0; i--)
    begin
      o_si <= tx[i];
      #62.5 o_sck <= 1'b1;
      rx = {rx[6:0], i_so_oe ? i_so : 1'bx};
      #62.5 o_sck <= 1'b0;
    end
    #62.5 o_ce_n <= 1'b1;
    o_si <= ~o_si;
    o_rx <= rx;
    o_rx_valid <= chk;
    // Deselect gap keeps well over four system clocks between frames
    #100 o_rx_valid <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### test/testbench.sv
// Self-checking bench for the flash write-protect and status block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic wp_n = 1'b1;
  logic lock_nv = 1'b0;
  logic sck, ce_n, si, so, so_oe, rx_valid, prog_valid, prog_word;
  logic erase_valid, lock_set;
  logic [7:0] rx, d, st;
  logic [2:0] lvl;
  logic [19:0] prog_addr, erase_addr, a;
  logic [15:0] prog_data;
  fwp_pkg::fwp_erase_e erase_kind;
  logic [31:0] notes[$];
  logic [31:0] seen;
  int miscompares = 0;
  int n_compared = 0;
  int seed = 32'hb4c7;
  int bases[8] = '{'h100000, 'hf0000, 'he0000, 'hc0000, 'h80000, 0, 0, 0};
  logic wp_tab[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  logic [7:0] wd_tab[4] = '{8'h8c, 8'h00, 8'h43, 8'h10};
  logic [7:0] ex_tab[4] = '{8'h8c, 8'h8e, 8'h00, 8'h10};
  always #5 i_clock = ~i_clock;
  fwp_write_protect #(.P_PROG_CYC(5), .P_ERASE_CYC(20), .P_CHIP_CYC(3000))
  fwp_write_protect_inst (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_sck(sck), .i_ce_n(ce_n), .i_si(si), .i_wp_n(wp_n),
    .i_secid_lock_nv(lock_nv), .o_so(so), .o_so_oe(so_oe),
    .o_prog_valid(prog_valid), .o_prog_word(prog_word),
    .o_prog_addr(prog_addr), .o_prog_data(prog_data),
    .o_erase_valid(erase_valid), .o_erase_kind(erase_kind),
    .o_erase_addr(erase_addr), .o_secid_lock_set(lock_set), .o_status(st));
  fwp_host_model fwp_host_model_inst (.i_so(so), .i_so_oe(so_oe),
    .o_sck(sck), .o_ce_n(ce_n), .o_si(si), .o_rx_valid(rx_valid),
    .o_rx(rx));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] pop();
    if (notes.size() == 0)
      return 32'hffffffff;
    return notes.pop_front();
  endfunction
  task automatic cmd(input logic [47:0] tx, input int nb);
    logic [7:0] r;
    fwp_host_model_inst.xfer(tx, nb, 1'b0, r);
  endtask
  // This task sends only status reads while an operation runs
  task automatic poll();
    logic [7:0] r;
    r = 8'h01;
    for (int k = 0; k < 400 && r[0] !== 1'b0; k++)
      fwp_host_model_inst.xfer(48'h0500, 2, 1'b0, r);
    check(r[0], 1'b0);
  endtask
  task automatic expect_rd(input logic [31:0] tx, input int nb,
    input logic [7:0] e);
    logic [7:0] r;
    notes.push_back({24'h200000, e});
    fwp_host_model_inst.xfer({16'h0, tx}, nb, 1'b1, r);
  endtask
  task automatic sid_prog(input logic [7:0] idx, input logic [7:0] v);
    cmd(48'h06, 1);
    cmd({8'ha5, idx, v}, 3);
    poll();
  endtask
  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge rx_valid)
    check({24'h200000, rx}, pop());
  always @(posedge i_clock)
  begin
    seen = prog_valid ? {prog_word ? 4'h2 : 4'h1, prog_addr,
      prog_data[15:8] ^ prog_data[7:0]} : erase_valid ?
      {4'h3, erase_addr, 6'h0, erase_kind} : 32'h40000000;
    if (prog_valid === 1'b1 || erase_valid === 1'b1 || lock_set === 1'b1)
      check(seen, pop());
  end
  initial
  begin
    #1000000;
    miscompares++;
    final_report();
  end
  initial
  begin
    repeat (5) @(posedge i_clock);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clock);
    expect_rd(16'h0500, 2, 8'h1c);
    for (int c = 0; c < 8; c++)
    begin
      lvl = c;
      cmd(48'h06, 1);
      cmd({8'h01, 3'h0, lvl, 2'h0}, 2);
      poll();
      expect_rd(16'h0500, 2, {3'h0, lvl, 2'h0});
      for (int j = 0; j < 3; j++)
      begin
        a = (j == 2) ? $random(seed) : bases[c] - 1 + j;
        d = $random(seed);
        cmd(48'h06, 1);
        if (a < bases[c])
          notes.push_back({4'h1, a, d});
        cmd({8'h02, 4'h0, a, d}, 5);
        poll();
      end
      cmd(48'h06, 1);
      if (c == 0)
        notes.push_back({4'h3, 20'h0, 8'h03});
      cmd(48'hc7, 1);
      if (c == 0)
        expect_rd(16'h0500, 2, 8'h01);
      cmd(48'h06, 1);
      poll();
      if (c != 0)
        cmd(48'h04, 1);
      expect_rd(16'h0500, 2, {3'h0, lvl, 2'h0});
    end
    $display("test protection levels done");
    for (int t = 0; t < 4; t++)
    begin
      @(posedge i_clock) wp_n <= wp_tab[t];
      cmd(48'h06, 1);
      cmd({8'h01, wd_tab[t]}, 2);
      poll();
      expect_rd(16'h0500, 2, ex_tab[t]);
    end
    $display("test status lock done");
    expect_rd(32'h88080000, 4, 8'hff);
    sid_prog(8'h08, 8'ha5);
    sid_prog(8'h08, 8'h3c);
    expect_rd(32'h88080000, 4, 8'h24);
    sid_prog(8'h1f, 8'h5a);
    expect_rd(32'h881f0000, 4, 8'h5a);
    cmd(48'h06, 1);
    notes.push_back(32'h40000000);
    cmd(48'h85, 1);
    sid_prog(8'h08, 8'h00);
    expect_rd(32'h88080000, 4, 8'h24);
    expect_rd(16'h0500, 2, 8'h32);
    $display("test identifier done");
    cmd(48'h06, 1);
    notes.push_back({4'h3, 20'h12000, 8'h00});
    cmd(48'h20012345, 4);
    poll();
    cmd(48'h06, 1);
    notes.push_back({4'h3, 20'h78000, 8'h01});
    cmd(48'h52078123, 4);
    poll();
    cmd(48'h06, 1);
    cmd(48'hd8080000, 4);
    poll();
    cmd(48'h06, 1);
    notes.push_back({4'h2, 20'h7fffc, 8'h99});
    cmd(48'had07fffd5ac3, 6);
    expect_rd(16'h0500, 2, 8'h72);
    notes.push_back({4'h2, 20'h7fffe, 8'hff});
    cmd(48'had0ff0, 3);
    poll();
    expect_rd(16'h0500, 2, 8'h30);
    $display("test erase and auto mode done");
    @(posedge i_clock) lock_nv <= 1'b1;
    i_rst_n <= 1'b0;
    repeat (5) @(posedge i_clock);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clock);
    expect_rd(16'h0500, 2, 8'h3c);
    repeat (20) @(posedge i_clock);
    check(st, 8'h3c);
    check(notes.size(), 0);
    final_report();
  end
endmodule
`default_nettype wire
